// ==== dsl_serial_load.v ====
`include "dsl_defines.vh"
`default_nettype none
// Overview of operation
// - serial clock rising edge with chip select low shifts data bit in
// - shift register holds while select high or clock steady
// - only last 18 bits shifted are used at select rise
// - word is MSB first: two address bits then 16 code bits
// - select rising edge loads code into addressed input registers
// - address 00 none, 01 channel A, 10 channel B, 11 both
// - load strobe low makes DAC registers follow input registers
// - preset low forces input and DAC registers to zero or midscale by select pin; shift register keeps its bits
// - reset sets input and DAC registers to zero or midscale until a load
module dsl_serial_load #(
	parameter WORD_BITS = `DSL_WORD_BITS,
	parameter CODE_BITS = `DSL_CODE_BITS
) (
	input wire MCLK,
	input wire SRST,
	input wire SERIAL_CLK,
	input wire CHIP_SEL_N,
	input wire SERIAL_DATA_IN,
	input wire DAC_LOAD_STROBE_N,
	input wire PRESET_CLEAR_N,
	input wire PRESET_MIDSCALE,
	output wire [CODE_BITS-1:0] INPUT_REG_A,
	output wire [CODE_BITS-1:0] INPUT_REG_B,
	output wire [CODE_BITS-1:0] DAC_REG_A,
	output wire [CODE_BITS-1:0] DAC_REG_B,
	output wire [WORD_BITS-1:0] SHIFT_REG,
	output wire LOAD_PULSE
);
	wire [4:0] pins_sync;
	reg sclk_d_ff;
	reg cs_n_d_ff;
	reg [WORD_BITS-1:0] shift_ff;
	reg [CODE_BITS-1:0] in_a_ff;
	reg [CODE_BITS-1:0] in_b_ff;
	reg [CODE_BITS-1:0] dac_a_ff;
	reg [CODE_BITS-1:0] dac_b_ff;
	reg load_ff;
	reg [WORD_BITS-1:0] nxt_shift;
	reg [CODE_BITS-1:0] nxt_in_a;
	reg [CODE_BITS-1:0] nxt_in_b;
	reg [CODE_BITS-1:0] nxt_dac_a;
	reg [CODE_BITS-1:0] nxt_dac_b;
	wire sclk_s;
	wire cs_n_s;
	wire ser_data_s;
	wire strobe_n_s;
	wire preset_n_s;
	wire msb_s;
	wire shift_evt;
	wire load_evt;
	wire [1:0] addr;
	wire [CODE_BITS-1:0] preset_code;
	wire [CODE_BITS-1:0] load_code;
	wire hit_a;
	wire hit_b;

	function [CODE_BITS-1:0] preset_val;
		input mid;
		begin
			preset_val = mid ? `DSL_MID_CODE : `DSL_ZERO_CODE;
		end
	endfunction

	// one decoder serves both channels so they can never disagree on the table
	function chan_hit;
		input [1:0] code;
		input is_b;
		begin
			case (code)
				`DSL_ADDR_NONE: begin
					chan_hit = 1'b0;
				end
				`DSL_ADDR_A: begin
					chan_hit = ~is_b;
				end
				`DSL_ADDR_B: begin
					chan_hit = is_b;
				end
				`DSL_ADDR_AB: begin
					chan_hit = 1'b1;
				end
				default: begin
					chan_hit = 1'b0;
				end
			endcase
		end
	endfunction

	// every pin is foreign to MCLK, so all pass two flops; preset thus reaches the registers on the third clock
	dsl_sync #(.WIDTH(5)) u_sync (
		.clk(MCLK),
		.d({SERIAL_CLK, CHIP_SEL_N, SERIAL_DATA_IN, DAC_LOAD_STROBE_N, PRESET_CLEAR_N}),
		.q(pins_sync)
	);
	reg msb_s1_ff;
	reg msb_s2_ff;
	always @(posedge MCLK) begin
		msb_s1_ff <= PRESET_MIDSCALE;
		msb_s2_ff <= msb_s1_ff;
	end
	assign msb_s = msb_s2_ff;
	assign {sclk_s, cs_n_s, ser_data_s, strobe_n_s, preset_n_s} = pins_sync;

	// history resets to the idle low level of the link clock, so no false edge follows reset
	always @(posedge MCLK) begin
		if (SRST) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
		end
	end

	// select history resets high, so an idle select after reset never looks like a rising edge
	always @(posedge MCLK) begin
		if (SRST) begin
			cs_n_d_ff <= 1'b1;
		end else begin
			cs_n_d_ff <= cs_n_s;
		end
	end

	// data sampled at the same delayed edge as the clock, keeping setup relationship
	assign shift_evt = sclk_s & ~sclk_d_ff & ~cs_n_s;
	assign load_evt = cs_n_s & ~cs_n_d_ff;
	assign addr = {shift_ff[`DSL_ADDR_HI_POS], shift_ff[`DSL_ADDR_LO_POS]};
	assign preset_code = preset_val(msb_s);
	assign load_code = shift_ff[CODE_BITS-1:0];
	assign hit_a = load_evt & chan_hit(addr, 1'b0);
	assign hit_b = load_evt & chan_hit(addr, 1'b1);

	// extra leading bits fall off the top, so only the last word counts at select rise
	always @* begin
		nxt_shift = shift_ff;
		if (shift_evt) begin
			nxt_shift = {shift_ff[WORD_BITS-2:0], ser_data_s};
		end
	end

	// preset is applied last so it wins over a load in the same cycle
	always @* begin
		nxt_in_a = in_a_ff;
		if (hit_a) begin
			nxt_in_a = load_code;
		end
		if (!preset_n_s) begin
			nxt_in_a = preset_code;
		end
	end

	always @* begin
		nxt_in_b = in_b_ff;
		if (hit_b) begin
			nxt_in_b = load_code;
		end
		if (!preset_n_s) begin
			nxt_in_b = preset_code;
		end
	end

	// transparent path sees the freshly loaded input value in the same cycle
	always @* begin
		nxt_dac_a = dac_a_ff;
		if (!strobe_n_s) begin
			nxt_dac_a = nxt_in_a;
		end
		if (!preset_n_s) begin
			nxt_dac_a = preset_code;
		end
	end

	always @* begin
		nxt_dac_b = dac_b_ff;
		if (!strobe_n_s) begin
			nxt_dac_b = nxt_in_b;
		end
		if (!preset_n_s) begin
			nxt_dac_b = preset_code;
		end
	end

	always @(posedge MCLK) begin
		if (SRST) begin
			shift_ff <= {WORD_BITS{1'b0}};
		end else begin
			shift_ff <= nxt_shift;
		end
	end

	// pulse marks the cycle after every select rise, even one with address 00 that loads no code
	always @(posedge MCLK) begin
		if (SRST) begin
			load_ff <= 1'b0;
		end else begin
			load_ff <= load_evt;
		end
	end

	// midscale strap is read live at reset, not latched
	always @(posedge MCLK) begin
		if (SRST) begin
			in_a_ff <= preset_code;
			in_b_ff <= preset_code;
		end else begin
			in_a_ff <= nxt_in_a;
			in_b_ff <= nxt_in_b;
		end
	end

	// reset follows the strap too, so power-up and preset agree
	always @(posedge MCLK) begin
		if (SRST) begin
			dac_a_ff <= preset_code;
			dac_b_ff <= preset_code;
		end else begin
			dac_a_ff <= nxt_dac_a;
			dac_b_ff <= nxt_dac_b;
		end
	end

	assign INPUT_REG_A = in_a_ff;
	assign INPUT_REG_B = in_b_ff;
	assign DAC_REG_A = dac_a_ff;
	assign DAC_REG_B = dac_b_ff;
	assign SHIFT_REG = shift_ff;
	assign LOAD_PULSE = load_ff;
endmodule // dsl_serial_load
`default_nettype wire

// ==== dsl_defines.vh ====
`ifndef DSL_DEFINES_VH
`define DSL_DEFINES_VH
`define DSL_WORD_BITS 18
`define DSL_CODE_BITS 16
`define DSL_ADDR_HI_POS 17
`define DSL_ADDR_LO_POS 16
`define DSL_ZERO_CODE 16'h0000
`define DSL_MID_CODE 16'h8000
`define DSL_ADDR_NONE 2'h0
`define DSL_ADDR_A 2'h1
`define DSL_ADDR_B 2'h2
`define DSL_ADDR_AB 2'h3
`define DSL_SYNC_STAGES 2
`endif

// ==== dsl_sync.v ====
`default_nettype none
module dsl_sync #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] stage1_ff;
	reg [WIDTH-1:0] stage2_ff;
	// first stage feeds only the second stage
	always @(posedge clk) begin
		stage1_ff <= d;
		stage2_ff <= stage1_ff;
	end
	assign q = stage2_ff;
endmodule // dsl_sync
`default_nettype wire

// ==== dsl_serial_load_properties.sv ====
`default_nettype none
module dsl_chk (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic CHIP_SEL_N,
	input wire logic DAC_LOAD_STROBE_N,
	input wire logic PRESET_CLEAR_N,
	input wire logic PRESET_MIDSCALE,
	input wire logic [15:0] INPUT_REG_A,
	input wire logic [15:0] INPUT_REG_B,
	input wire logic [15:0] DAC_REG_A,
	input wire logic [17:0] SHIFT_REG,
	input wire logic LOAD_PULSE
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [15:0] pv = PRESET_MIDSCALE ? 16'h8000 : 16'h0000;
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	chk_pulse_one: assert property (LOAD_PULSE |=> !LOAD_PULSE) else $error("pulse");
	chk_load_cause: assert property (LOAD_PULSE |-> $past(CHIP_SEL_N, 2) && !$past(CHIP_SEL_N, 6))
		else $error("cause");
	chk_shift_step: assert property (!$stable(SHIFT_REG) |-> SHIFT_REG[17:1] == $past(SHIFT_REG[16:0]))
		else $error("shift");
	chk_shift_hold: assert property (CHIP_SEL_N [*6] |-> $stable(SHIFT_REG)) else $error("hold");
	chk_load_a: assert property (LOAD_PULSE |-> INPUT_REG_A ==
		(SHIFT_REG[16] ? SHIFT_REG[15:0] : $past(INPUT_REG_A, 2))) else $error("a");
	chk_load_b: assert property (LOAD_PULSE |-> INPUT_REG_B ==
		(SHIFT_REG[17] ? SHIFT_REG[15:0] : $past(INPUT_REG_B, 2))) else $error("b");
	chk_dac_follow: assert property ((!DAC_LOAD_STROBE_N && PRESET_CLEAR_N) [*4] |-> DAC_REG_A == INPUT_REG_A)
		else $error("follow");
	chk_preset_val: assert property ((!PRESET_CLEAR_N && $stable(PRESET_MIDSCALE)) [*4] |->
		INPUT_REG_A == pv && INPUT_REG_B == pv && DAC_REG_A == pv) else $error("preset");
	cover property (LOAD_PULSE && SHIFT_REG[17:16] == 2'h3);
	cover property (LOAD_PULSE && DAC_LOAD_STROBE_N);
	cover property (!PRESET_CLEAR_N);
endmodule // dsl_chk
bind dsl_serial_load dsl_chk chk (.*);
`default_nettype wire

// ==== dsl_host.sv ====
`default_nettype none
module dsl_host (
	output var logic SCK,
	output var logic CS_N,
	output var logic SER_DATA
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {SCK, CS_N, SER_DATA} = 3'h2;
	// clock stands low between frames; released data shows the inverse
	task automatic send(input logic [23:0] w, input int n);
		#37 CS_N = 0;
		for (int i = n - 1; i >= 0; i--) begin
			SER_DATA = w[i];
			#400 SCK = 1;
			#400 SCK = 0;
		end
		#400 CS_N = 1;
		SER_DATA = !SER_DATA;
		// select stays high long enough for the device to see its rising edge
		#800;
	endtask
endmodule // dsl_host
`default_nettype wire

// ==== test_dsl_serial_load.sv ====
`default_nettype none
module test_dsl_serial_load;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, srst = 1, ldn = 0, pcn = 1, mid = 1; // preset idle high
	wire logic sck, csn, sdat, lp;
	wire logic [17:0] sr;
	wire logic [15:0] ia, ib, da, db;
	int seed = 31, miscompares = 0, n_compared = 0;
	logic [31:0] e = 32'h80008000, h;
	logic [31:0] q[$];
	always #50 mclk = ~mclk;
	dsl_host host (.SCK(sck), .CS_N(csn), .SER_DATA(sdat));
	dsl_serial_load uut (.MCLK(mclk), .SRST(srst), .SERIAL_CLK(sck), .CHIP_SEL_N(csn), .SERIAL_DATA_IN(sdat),
		.DAC_LOAD_STROBE_N(ldn), .PRESET_CLEAR_N(pcn), .PRESET_MIDSCALE(mid), .INPUT_REG_A(ia),
		.INPUT_REG_B(ib), .DAC_REG_A(da), .DAC_REG_B(db), .SHIFT_REG(sr), .LOAD_PULSE(lp));
	task check(string nm, logic [31:0] s, x);
		n_compared++;
		if (s !== x) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// an unaddressed frame leaves no note; it still pulses, but its pulse finds the queue empty
	task frame(logic [1:0] a, int n);
		logic [15:0] c;
		c = 16'($random(seed));
		if (a[0]) e[31:16] = c;
		if (a[1]) e[15:0] = c;
		if (a != 0) q.push_back(e);
		host.send({6'($random(seed)), a, c}, n);
		for (int k = 0; k < 30 && q.size() > 0; k++) @(posedge mclk);
		if (q.size() > 0) begin
			miscompares++;
			results;
		end
		check("shift", sr, {a, c});
		$display("frame addr %0d bits %0d done", a, n);
		@(posedge mclk);
		#1;
	endtask
	always @(posedge mclk) if (lp === 1'b1 && q.size() > 0) check("inputs", {ia, ib}, q.pop_front());
	initial begin
		repeat (16) @(posedge mclk);
		#1 srst = 0;
		repeat (4) @(posedge mclk);
		#1 check("reset", {ia, db}, e);
		$display("reset test done");
		for (int i = 0; i < 8; i++) frame(i[1:0], i[0] ? 24 : 18);
		h = {da, db};
		ldn = 1;
		frame(2'h3, 18);
		check("latched", {da, db}, h);
		$display("latch test done");
		ldn = 0;
		repeat (5) @(posedge mclk);
		#1 check("follow", {da, db}, e);
		$display("follow test done");
		mid = 0;
		pcn = 0;
		repeat (5) @(posedge mclk);
		#1 check("preset", {ia, db}, 0);
		$display("preset test done");
		results;
	end
endmodule // test_dsl_serial_load
`default_nettype wire
